/* hdl/pcr_pkg.sv */
// Package of offsets, field layouts, defaults and bus types for the capability register bank
package pcr_pkg;

    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [7:0] OFS_CAP_HEADER = 8'h40;
    localparam logic [7:0] OFS_DEV_CAPS   = 8'h44;
    localparam logic [7:0] OFS_LOCK_CTRL  = 8'h80;

    // ****************************************************************
    // Header field positions and values
    // ****************************************************************
    localparam int          HDR_NEXT_LSB   = 8;
    localparam int          HDR_REV_LSB    = 16;
    localparam int          HDR_TYPE_LSB   = 20;
    localparam int          HDR_SLOT_BIT   = 24;
    localparam int          HDR_TCR_BIT    = 30;
    localparam logic [7:0]  CAP_ID_EXPRESS = 8'h10;
    localparam logic [7:0]  NEXT_PTR_RST   = 8'hc0;
    localparam logic [3:0]  REVISION_RST   = 4'h1;
    localparam logic [3:0]  TYPE_UPSTREAM  = 4'h5;
    localparam logic [3:0]  TYPE_DOWNSTRM  = 4'h6;
    localparam logic        SLOT_RST       = 1'h0;
    localparam logic        TCR_RST        = 1'h1;

    // ****************************************************************
    // Device capabilities field positions and values
    // ****************************************************************
    localparam int          DC_WTAG_BIT    = 5;
    localparam int          DC_ROLE_BIT    = 15;
    localparam int          DC_PVAL_LSB    = 18;
    localparam int          DC_PSCL_LSB    = 26;
    localparam logic [2:0]  PAYLOAD_RST    = 3'h4;
    localparam logic        WTAG_RST       = 1'h1;
    localparam logic        ROLE_ERR_RO    = 1'h1;

    // Scale codes of the captured power limit
    localparam logic [1:0]  SCALE_X1       = 2'h0;
    localparam logic [1:0]  SCALE_X0P1     = 2'h1;
    localparam logic [1:0]  SCALE_X0P01    = 2'h2;
    localparam logic [1:0]  SCALE_X0P001   = 2'h3;

    // AXI responses
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    // Lock control: bit 0 is the lock, reset locked
    localparam logic        LOCK_RST       = 1'h1;

    // Write request carried from bus slave to register bank
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] data;
        logic [3:0]  strb;
    } pcr_wreq_s;

    // Captured slot power message
    typedef struct packed {
        logic [7:0]  value;
        logic [1:0]  scale;
    } pcr_power_s;

endpackage

/* hdl/pcr_axi_slave.sv */
// AXI4-Lite slave front end that turns bus writes into single-cycle strobes and passes the read address straight through
`timescale 1ns/1ps

module pcr_axi_slave #(
    parameter int ADDR_W = 8
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output pcr_pkg::pcr_wreq_s     wr_req,
    output logic                   wr_stb,
    input  wire logic              wr_err,
    output logic [ADDR_W-1:0]      rd_addr,
    input  wire logic [31:0]       rd_data,
    input  wire logic              rd_err
);

    // ****************************************************************
    // Write path: address and data latched in either order
    // ****************************************************************
    logic              aw_have_r;
    logic              w_have_r;
    logic [ADDR_W-1:0] aw_addr_r;
    logic [31:0]       w_data_r;
    logic [3:0]        w_strb_r;
    logic              bvalid_r;
    logic [1:0]        bresp_r;
    wire               aw_take = s_axi_awvalid && s_axi_awready;
    wire               w_take  = s_axi_wvalid && s_axi_wready;
    wire               do_wr   = aw_have_r && w_have_r && !bvalid_r;

    // Ready drops while a word is held, so a second write waits for the response
    assign s_axi_awready = !aw_have_r && !bvalid_r;
    assign s_axi_wready  = !w_have_r && !bvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign wr_stb        = do_wr;
    assign wr_req        = '{addr: 8'(aw_addr_r), data: w_data_r, strb: w_strb_r};

    // Capture halves, then answer one cycle after both are present
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            aw_addr_r <= '0;
            w_data_r  <= '0;
            w_strb_r  <= '0;
            bvalid_r  <= 1'b0;
            bresp_r   <= pcr_pkg::RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_have_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (w_take) begin
                w_have_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_have_r <= 1'b0;
                w_have_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                bresp_r   <= wr_err ? pcr_pkg::RESP_SLVERR : pcr_pkg::RESP_OKAY;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Read path: data registered one cycle after the address
    // ****************************************************************
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;
    wire         ar_take = s_axi_arvalid && s_axi_arready;

    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;
    assign rd_addr       = s_axi_araddr;

    // Bank decodes the live address; sample its answer on the take
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r  <= '0;
            rresp_r  <= pcr_pkg::RESP_OKAY;
        end else if (ar_take) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_data;
            rresp_r  <= rd_err ? pcr_pkg::RESP_SLVERR : pcr_pkg::RESP_OKAY;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

endmodule

/* hdl/pcr_capability_regs.sv */
// Capability header and device capabilities register bank of one switch port
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

module pcr_capability_regs #(
    parameter bit UPSTREAM = 1'b1
) (
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire logic [7:0]         s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [7:0]         s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    input  wire logic               power_msg_valid,
    input  wire pcr_pkg::pcr_power_s power_msg,
    input  wire logic               init_wr_en,
    output logic [7:0]              power_limit_value,
    output logic [1:0]              power_limit_scale
);

    // ****************************************************************
    // Bus front end
    // ****************************************************************
    pcr_pkg::pcr_wreq_s wr_req;
    logic               wr_stb;
    logic [7:0]         rd_addr;
    logic [31:0]        rd_data;
    logic               rd_err;
    logic               wr_err;

    pcr_axi_slave #(.ADDR_W(8)) u_slave (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr_req        (wr_req),
        .wr_stb        (wr_stb),
        .wr_err        (wr_err),
        .rd_addr       (rd_addr),
        .rd_data       (rd_data),
        .rd_err        (rd_err)
    );

    // ****************************************************************
    // Address decode
    // ****************************************************************
    function automatic logic [1:0] decode(input logic [7:0] a);
        // One-hot: bit0 header, bit1 device caps; lock reg flagged separately
        if (a == pcr_pkg::OFS_CAP_HEADER)
            return 2'h1;
        else if (a == pcr_pkg::OFS_DEV_CAPS)
            return 2'h2;
        else
            return 2'h0;
    endfunction

    wire [1:0] wr_sel   = decode(wr_req.addr);
    wire       wr_lock  = (wr_req.addr == pcr_pkg::OFS_LOCK_CTRL);
    wire [1:0] rd_sel   = decode(rd_addr);
    wire       rd_lock  = (rd_addr == pcr_pkg::OFS_LOCK_CTRL);
    assign     wr_err   = (wr_sel == 2'h0) && !wr_lock;
    assign     rd_err   = (rd_sel == 2'h0) && !rd_lock;

    // ****************************************************************
    // Lockable fields
    // ****************************************************************
    logic       lock_r;
    logic [7:0] next_ptr_r;
    logic [3:0] revision_r;
    logic       slot_r;
    logic       tc_route_r;
    logic [2:0] payload_r;
    logic       wide_tag_r;

    // Writes land only when unlocked or when the init path is asserted
    wire        open_wr  = wr_stb && (!lock_r || init_wr_en);
    wire        hdr_wr   = open_wr && wr_sel[0];
    wire        dc_wr    = open_wr && wr_sel[1];
    wire [31:0] wd       = wr_req.data;
    wire [3:0]  ws       = wr_req.strb;

    // Lock bit is a plain control word, held set after reset
    always_ff @(posedge aclk) begin
        if (!aresetn)
            lock_r <= pcr_pkg::LOCK_RST;
        else if (wr_stb && wr_lock && ws[0])
            lock_r <= wd[0];
    end

    // Header lockable fields, byte lanes honoured
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            next_ptr_r <= pcr_pkg::NEXT_PTR_RST;
            revision_r <= pcr_pkg::REVISION_RST;
            slot_r     <= pcr_pkg::SLOT_RST;
            tc_route_r <= pcr_pkg::TCR_RST;
        end else if (hdr_wr) begin
            if (ws[1])
                next_ptr_r <= wd[pcr_pkg::HDR_NEXT_LSB +: 8];
            if (ws[2])
                revision_r <= wd[pcr_pkg::HDR_REV_LSB +: 4];
            if (ws[3])
                slot_r     <= wd[pcr_pkg::HDR_SLOT_BIT];
            if (ws[3])
                tc_route_r <= wd[pcr_pkg::HDR_TCR_BIT];
        end
    end

    // Device capabilities lockable fields
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            payload_r  <= pcr_pkg::PAYLOAD_RST;
            wide_tag_r <= pcr_pkg::WTAG_RST;
        end else if (dc_wr && ws[0]) begin
            payload_r  <= wd[2:0];
            wide_tag_r <= wd[pcr_pkg::DC_WTAG_BIT];
        end
    end

    // ****************************************************************
    // Captured slot power limit
    // ****************************************************************
    pcr_pkg::pcr_power_s power_r;

    // Downstream ports never load; software cannot write these fields
    always_ff @(posedge aclk) begin
        if (!aresetn)
            power_r <= '0;
        else if (UPSTREAM && power_msg_valid)
            power_r <= power_msg;
    end

    // Scale code passed out raw; consumer applies 1.0x/0.1x/0.01x/0.001x
    assign power_limit_value = power_r.value;
    assign power_limit_scale = power_r.scale;

    // ****************************************************************
    // Read data assembly
    // ****************************************************************
    wire [3:0]  port_type = UPSTREAM ? pcr_pkg::TYPE_UPSTREAM : pcr_pkg::TYPE_DOWNSTRM;
    wire [31:0] hdr_word;
    wire [31:0] dc_word;

    // Reserved, message index, latency and presence bits are constant zero
    assign hdr_word = {1'b0,
                       tc_route_r,
                       5'h00,
                       slot_r,
                       port_type,
                       revision_r,
                       next_ptr_r,
                       pcr_pkg::CAP_ID_EXPRESS};
    assign dc_word  = {4'h0,
                       power_r.scale,
                       power_r.value,
                       2'h0,
                       pcr_pkg::ROLE_ERR_RO,
                       3'h0,
                       6'h00,
                       wide_tag_r,
                       2'h0,
                       payload_r};

    // Unmapped reads return zero with an error response
    assign rd_data = rd_sel[0] ? hdr_word :
                     rd_sel[1] ? dc_word :
                     rd_lock   ? {31'h0, lock_r} : 32'h0;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    sequence s_locked_write;
        wr_stb && lock_r && !init_wr_en && (wr_sel != 2'h0);
    endsequence

    chk_cap_id_fixed: assert property (@(posedge aclk) disable iff (!aresetn)
        hdr_word[7:0] == 8'h10) else $error("capability id not fixed");

    chk_port_type: assert property (@(posedge aclk) disable iff (!aresetn)
        hdr_word[23:20] == (UPSTREAM ? 4'h5 : 4'h6)) else $error("port type wrong");

    chk_hdr_zeros: assert property (@(posedge aclk) disable iff (!aresetn)
        hdr_word[31] == 1'b0 && hdr_word[29:25] == 5'h00) else $error("header zero bits set");

    chk_dc_fixed: assert property (@(posedge aclk) disable iff (!aresetn)
        dc_word[14:3] == 12'h000 || dc_word[14:3] == 12'h004) else $error("hardwired caps bits set");

    chk_role_one: assert property (@(posedge aclk) disable iff (!aresetn)
        dc_word[15] && dc_word[17:16] == 2'h0 && dc_word[31:28] == 4'h0) else $error("caps constant bits wrong");

    chk_lock_holds: assert property (@(posedge aclk) disable iff (!aresetn)
        s_locked_write |=> $stable(hdr_word) && $stable(dc_word[5:0])) else $error("locked field changed");

    chk_power_load: assert property (@(posedge aclk) disable iff (!aresetn)
        power_msg_valid |=> dc_word[27:18] == (UPSTREAM ? {$past(power_msg.scale), $past(power_msg.value)}
                                                        : 10'h000))
        else $error("power capture wrong");

    chk_power_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        !power_msg_valid |=> $stable(power_limit_value) && $stable(power_limit_scale))
        else $error("power value changed without message");

    chk_reset_vals: assert property (@(posedge aclk)
        !aresetn |=> hdr_word[30:8] == {pcr_pkg::TCR_RST, 5'h00, pcr_pkg::SLOT_RST, port_type,
                                        pcr_pkg::REVISION_RST, pcr_pkg::NEXT_PTR_RST}
                     && dc_word[5:0] == 6'h24)
        else $error("reset defaults wrong");

endmodule

/* testbench/pcr_capability_regs_test.sv */
// Self-checking testbench of the capability register bank over AXI4-Lite
`timescale 1ns/1ps

module pcr_capability_regs_test;
    // Bus, message and result signals; all inputs valued at time zero
    logic                aclk            = 1'b0;
    logic                aresetn         = 1'b0;
    logic [7:0]          s_axi_awaddr    = 8'h00;
    logic                s_axi_awvalid   = 1'b0;
    logic [31:0]         s_axi_wdata     = 32'h0;
    logic [3:0]          s_axi_wstrb     = 4'h0;
    logic                s_axi_wvalid    = 1'b0;
    logic                s_axi_bready    = 1'b0;
    logic [7:0]          s_axi_araddr    = 8'h00;
    logic                s_axi_arvalid   = 1'b0;
    logic                s_axi_rready    = 1'b0;
    logic                power_msg_valid = 1'b0;
    pcr_pkg::pcr_power_s power_msg       = '0;
    logic                init_wr_en      = 1'b0;
    logic                dn_slot         = 1'b0;
    logic                s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]          s_axi_bresp, s_axi_rresp, power_limit_scale, dn_scale;
    logic [31:0]         s_axi_rdata, dn_rdata;
    logic [7:0]          power_limit_value, dn_value, pv;
    logic [1:0]          ps;
    int                  mismatches      = 0;
    int                  check_count     = 0;

    always #12.5 aclk = ~aclk;

    // Upstream port under test
    pcr_capability_regs #(.UPSTREAM(1'b1)) dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .power_msg_valid(power_msg_valid), .power_msg(power_msg), .init_wr_en(init_wr_en),
        .power_limit_value(power_limit_value), .power_limit_scale(power_limit_scale));

    // Downstream twin on the same bus; it answers in step, so only its data is taken
    pcr_capability_regs #(.UPSTREAM(1'b0)) dut_dn (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(), .s_axi_wdata(s_axi_wdata | {7'h00, dn_slot, 24'h000000}), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(), .s_axi_rdata(dn_rdata), .s_axi_rresp(), .s_axi_rvalid(),
        .s_axi_rready(s_axi_rready), .power_msg_valid(power_msg_valid), .power_msg(power_msg),
        .init_wr_en(init_wr_en), .power_limit_value(dn_value), .power_limit_scale(dn_scale));

    // ****************************************************************
    // Compare, report and bus tasks
    // ****************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize;
        $display("Counts: %0d compares, %0d mismatches", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Both halves offered together; each dropped only once its own ready was seen
    task automatic wr(input logic [7:0] a, input logic [31:0] dat, input logic [3:0] st, input logic [1:0] er);
        int   n;
        logic done;
        n = 0;
        done = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= dat;
        s_axi_wstrb <= st;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!done && n < 100) begin
            @(posedge aclk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                done = 1'b1;
                s_axi_bready <= 1'b0;
                check({30'h0, s_axi_bresp}, {30'h0, er});
            end
        end
        if (!done) begin
            mismatches++;
            summarize();
        end
    endtask

    // Read of one word; both port flavours are compared in the same cycle
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] exp_dn, input logic [1:0] er);
        int   n;
        logic done;
        n = 0;
        done = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!done && n < 100) begin
            @(posedge aclk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                done = 1'b1;
                s_axi_rready <= 1'b0;
                check(s_axi_rdata, exp);
                check(dn_rdata, exp_dn);
                check({30'h0, s_axi_rresp}, {30'h0, er});
            end
        end
        if (!done) begin
            mismatches++;
            summarize();
        end
    endtask

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd(pcr_pkg::OFS_CAP_HEADER, 32'h4051c010, 32'h4061c010, 2'h0);
        rd(pcr_pkg::OFS_DEV_CAPS, 32'h00008024, 32'h00008024, 2'h0);
        rd(pcr_pkg::OFS_LOCK_CTRL, 32'h1, 32'h1, 2'h0);
        $display("Test done: reset values");
        // Locked bank: every bit written high must leave the words untouched
        wr(pcr_pkg::OFS_CAP_HEADER, 32'hffffffff, 4'hf, 2'h0);
        wr(pcr_pkg::OFS_DEV_CAPS, 32'hffffffff, 4'hf, 2'h0);
        rd(pcr_pkg::OFS_CAP_HEADER, 32'h4051c010, 32'h4061c010, 2'h0);
        rd(pcr_pkg::OFS_DEV_CAPS, 32'h00008024, 32'h00008024, 2'h0);
        rd(8'h48, 32'h0, 32'h0, 2'h2);
        rd(8'h41, 32'h0, 32'h0, 2'h2);
        wr(8'h4c, 32'hffffffff, 4'hf, 2'h2);
        $display("Test done: locked and unmapped");
        // Every scale code once; the downstream twin must ignore the message
        for (int s = 0; s < 4; s++) begin
            ps = 2'(s);
            pv = 8'h5a + 8'(s * 8'h33);
            @(posedge aclk);
            power_msg_valid <= 1'b1;
            power_msg <= {pv, ps};
            @(posedge aclk);
            power_msg_valid <= 1'b0;
            @(posedge aclk);
            check({22'h0, power_limit_value, power_limit_scale}, {22'h0, pv, ps});
            check({22'h0, dn_value, dn_scale}, 32'h0);
            rd(pcr_pkg::OFS_DEV_CAPS, {4'h0, ps, pv, 18'h08024}, 32'h00008024, 2'h0);
        end
        $display("Test done: power message");
        // Unlocked: lockable fields follow writes, read-only ones do not
        wr(pcr_pkg::OFS_LOCK_CTRL, 32'h0, 4'h1, 2'h0);
        rd(pcr_pkg::OFS_LOCK_CTRL, 32'h0, 32'h0, 2'h0);
        // Slot bit stays zero upstream; only the downstream twin sees it set
        dn_slot <= 1'b1;
        wr(pcr_pkg::OFS_CAP_HEADER, 32'hfeffffff, 4'hf, 2'h0);
        dn_slot <= 1'b0;
        rd(pcr_pkg::OFS_CAP_HEADER, 32'h405fff10, 32'h416fff10, 2'h0);
        wr(pcr_pkg::OFS_CAP_HEADER, 32'h0, 4'hf, 2'h0);
        rd(pcr_pkg::OFS_CAP_HEADER, 32'h00500010, 32'h00600010, 2'h0);
        wr(pcr_pkg::OFS_CAP_HEADER, 32'hffffffff, 4'h2, 2'h0);
        rd(pcr_pkg::OFS_CAP_HEADER, 32'h0050ff10, 32'h0060ff10, 2'h0);
        wr(pcr_pkg::OFS_DEV_CAPS, 32'hffffffff, 4'hf, 2'h0);
        rd(pcr_pkg::OFS_DEV_CAPS, {4'h0, ps, pv, 18'h08027}, 32'h00008027, 2'h0);
        wr(pcr_pkg::OFS_DEV_CAPS, 32'h0, 4'hf, 2'h0);
        rd(pcr_pkg::OFS_DEV_CAPS, {4'h0, ps, pv, 18'h08000}, 32'h00008000, 2'h0);
        $display("Test done: unlocked writes");
        // Relocked, then the privileged path gets through the lock
        wr(pcr_pkg::OFS_LOCK_CTRL, 32'h1, 4'h1, 2'h0);
        wr(pcr_pkg::OFS_CAP_HEADER, 32'hffffffff, 4'hf, 2'h0);
        rd(pcr_pkg::OFS_CAP_HEADER, 32'h0050ff10, 32'h0060ff10, 2'h0);
        @(posedge aclk);
        init_wr_en <= 1'b1;
        wr(pcr_pkg::OFS_CAP_HEADER, 32'h00010000, 4'h4, 2'h0);
        wr(pcr_pkg::OFS_DEV_CAPS, 32'h00000004, 4'h1, 2'h0);
        rd(pcr_pkg::OFS_CAP_HEADER, 32'h0051ff10, 32'h0061ff10, 2'h0);
        rd(pcr_pkg::OFS_DEV_CAPS, {4'h0, ps, pv, 18'h08004}, 32'h00008004, 2'h0);
        init_wr_en <= 1'b0;
        $display("Test done: init path");
        // Second reset mid-run restores every default
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(pcr_pkg::OFS_CAP_HEADER, 32'h4051c010, 32'h4061c010, 2'h0);
        rd(pcr_pkg::OFS_DEV_CAPS, 32'h00008024, 32'h00008024, 2'h0);
        $display("Test done: second reset");
        summarize();
    end
endmodule
